// [pwm_out_pkg.sv]
// package: register map, field layouts and reset values of the pwm output stage
package pwm_out_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] PIN_OUTPUT_CONTROL_OFS  = 8'h00;
  localparam logic [7:0] FAULT_LIMIT_CONTROL_OFS = 8'h04;
  localparam logic [7:0] PRIMARY_TRIGGER_OFS     = 8'h08;
  localparam logic [7:0] SECONDARY_TRIGGER_OFS   = 8'h0c;
  localparam logic [7:0] OUTPUT_STATUS_OFS       = 8'h10;

  // values after reset
  localparam logic [15:0] PIN_OUTPUT_CONTROL_RST  = 16'h0000;
  localparam logic [15:0] FAULT_LIMIT_CONTROL_RST = 16'h0000;
  localparam logic [12:0] TRIGGER_COMPARE_RST     = 13'h0000;

  // trigger compare field position
  localparam int TRIG_CMP_LSB = 3;

  // status register bit positions
  localparam int STAT_FAULT_LATCHED = 0;
  localparam int STAT_FAULT_CYCLE   = 1;
  localparam int STAT_FAULT_ACTIVE  = 2;
  localparam int STAT_LIMIT_ACTIVE  = 3;
  localparam int STAT_PUSH_PHASE    = 4;

  // pairing of the high and low outputs
  typedef enum logic [1:0] {
    PAIR_COMPLEMENTARY = 2'h0,
    PAIR_REDUNDANT     = 2'h1,
    PAIR_PUSH_PULL     = 2'h2,
    PAIR_INDEPENDENT   = 2'h3
  } pair_mode_t;

  // action taken on the selected fault input
  typedef enum logic [1:0] {
    FAULT_LATCHED  = 2'h0,
    FAULT_CYCLE    = 2'h1,
    FAULT_RESERVED = 2'h2,
    FAULT_DISABLED = 2'h3
  } fault_mode_t;

  // pin output control layout, msb first
  typedef struct packed {
    logic       high_pin_ownership;
    logic       low_pin_ownership;
    logic       high_pin_polarity;
    logic       low_pin_polarity;
    pair_mode_t pair_output_mode;
    logic       high_override_enable;
    logic       low_override_enable;
    logic [1:0] override_data;
    logic [1:0] fault_drive_data;
    logic [1:0] limit_drive_data;
    logic       pin_swap;
    logic       override_sync;
  } pin_cfg_t;

  // fault and current-limit control layout, msb first
  typedef struct packed {
    logic        independent_fault_mode;
    logic [4:0]  limit_source_select;
    logic        limit_source_polarity;
    logic        limit_function_enable;
    logic [4:0]  fault_source_select;
    logic        fault_source_polarity;
    fault_mode_t fault_action_mode;
  } fault_cfg_t;

  // override state as applied to the pins
  typedef struct packed {
    logic       high_enable;
    logic       low_enable;
    logic [1:0] data;
  } override_t;

endpackage

// [pwm_output_fault_trigger_ctrl.sv]
// pwm output stage: pin ownership, pairing, override, fault/limit forcing, adc triggers
//
// Summary of operation
// - ownership bit gives pin to generator else gpio
// - polarity bit makes pin active low
// - pairing field selects comp, redundant, push-pull, independent
// - high override enable drives high from data bit1
// - low override enable drives low from data bit0
// - normal mode limit drives pins from limit data
// - swap exchanges high and low pin signals
// - override sync applies changes on time base
// - limit source codes 0-7 pick inputs, rest reserved
// - limit polarity bit makes limit source active low
// - limit enable bit turns current limit on
// - fault source codes 0-7 pick inputs, rest reserved
// - fault polarity bit makes fault source active low
// - fault mode latched, cycle, reserved or disabled
// - primary compare triggers adc, low bits read zero
// - secondary trigger never raises trigger interrupt
// - secondary compare triggers adc, low bits read zero
`timescale 1ns/1ps

module pwm_output_fault_trigger_ctrl (
  input  wire logic        core_clk,          // 40 mhz core clock
  input  wire logic        rstn,              // async reset, active low
  input  wire logic        hsel,              // ahb slave select
  input  wire logic [7:0]  haddr,             // ahb byte address
  input  wire logic [1:0]  htrans,            // ahb transfer type
  input  wire logic        hwrite,            // ahb write strobe
  input  wire logic [2:0]  hsize,             // ahb transfer size
  input  wire logic [31:0] hwdata,            // ahb write data
  input  wire logic        hready,            // ahb bus ready
  output logic             hreadyout,         // ahb slave ready
  output logic [31:0]      hrdata,            // ahb read data
  output logic             hresp,             // ahb response, always okay
  input  wire logic        gen_high,          // generator high-side signal
  input  wire logic        gen_low,           // generator low-side signal
  input  wire logic        tb_sync,           // pulse at start of each pwm cycle
  input  wire logic [15:0] tb_count,          // primary local time base
  input  wire logic [15:0] sec_tb_count,      // secondary local time base
  input  wire logic        gpio_high,         // gpio data for high pin
  input  wire logic        gpio_low,          // gpio data for low pin
  input  wire logic [7:0]  fault_in,          // fault inputs 1..8 from pins
  output logic             high_side_output,  // high-side pin level
  output logic             low_side_output,   // low-side pin level
  output logic             high_pin_owned,    // high pin owned by generator
  output logic             low_pin_owned,     // low pin owned by generator
  output logic             adc_trig_primary,  // primary adc trigger pulse
  output logic             adc_trig_secondary,// secondary adc trigger pulse
  output logic             trig_int_req       // trigger interrupt request pulse
);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // configuration registers
  pwm_out_pkg::pin_cfg_t   pin_cfg_reg;       // pin output control
  pwm_out_pkg::fault_cfg_t fault_cfg_reg;     // fault and limit control
  logic [12:0]             prim_cmp_reg;      // primary compare, bits 15:3
  logic [12:0]             sec_cmp_reg;       // secondary compare, bits 15:3

  // bus pipeline
  logic                    wr_pend_reg;       // write data phase pending
  logic [7:0]              wr_addr_reg;       // latched write address
  logic                    addr_ok;           // valid address phase
  logic [31:0]             rd_next;           // read mux

  // input sync and fault state
  logic [7:0]              fault_sync1_reg;   // first sync stage only
  logic [7:0]              fault_sync2_reg;   // second sync stage
  logic                    fault_act;         // selected fault asserted
  logic                    limit_act;         // selected limit asserted
  logic                    fault_latched_reg; // latched fault memory
  logic                    fault_cycle_reg;   // cycle-by-cycle fault memory
  logic                    fault_force;       // fault forcing pins
  logic                    limit_force;       // limit forcing pins
  logic                    latch_clear;       // software clear of latch

  // output path
  pwm_out_pkg::override_t  ovr_reg;           // override as applied
  logic                    push_phase_reg;    // push-pull alternation
  logic                    pair_high;         // after pairing
  logic                    pair_low;
  logic                    sig_high;          // after override/fault
  logic                    sig_low;
  logic                    pin_high_next;     // final pin values
  logic                    pin_low_next;

  // triggers
  logic                    prim_match_reg;    // previous compare match
  logic                    sec_match_reg;
  logic                    prim_hit;          // rising match
  logic                    sec_hit;

  // pick one of eight inputs; reserved codes select nothing
  function automatic logic pick_source(input logic [4:0] code, input logic [7:0] vec);
    logic r;
    r = 1'b0;
    if (code[4:3] == 2'h0) begin
      r = vec[code[2:0]];
    end
    return r;
  endfunction

  assign addr_ok = hsel & hready & htrans[1];

  // address phase capture, zero wait states so ready stays high
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      wr_pend_reg <= addr_ok & hwrite;
      wr_addr_reg <= haddr;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (haddr)
      pwm_out_pkg::PIN_OUTPUT_CONTROL_OFS:  rd_next[15:0] = pin_cfg_reg;
      pwm_out_pkg::FAULT_LIMIT_CONTROL_OFS: rd_next[15:0] = fault_cfg_reg;
      pwm_out_pkg::PRIMARY_TRIGGER_OFS:     rd_next[15:0] = {prim_cmp_reg, 3'h0};
      pwm_out_pkg::SECONDARY_TRIGGER_OFS:   rd_next[15:0] = {sec_cmp_reg, 3'h0};
      pwm_out_pkg::OUTPUT_STATUS_OFS: begin
        rd_next[pwm_out_pkg::STAT_FAULT_LATCHED] = fault_latched_reg;
        rd_next[pwm_out_pkg::STAT_FAULT_CYCLE]   = fault_cycle_reg;
        rd_next[pwm_out_pkg::STAT_FAULT_ACTIVE]  = fault_act;
        rd_next[pwm_out_pkg::STAT_LIMIT_ACTIVE]  = limit_act;
        rd_next[pwm_out_pkg::STAT_PUSH_PHASE]    = push_phase_reg;
      end
      default: rd_next = 32'h0000_0000;
    endcase
  end

  // read data is loaded at the address phase edge, valid in the data phase
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok & !hwrite) begin
      hrdata <= rd_next;
    end
  end

  // register writes in the data phase; only low half-word is kept
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_cfg_reg   <= pwm_out_pkg::PIN_OUTPUT_CONTROL_RST;
      fault_cfg_reg <= pwm_out_pkg::FAULT_LIMIT_CONTROL_RST;
      prim_cmp_reg  <= pwm_out_pkg::TRIGGER_COMPARE_RST;
      sec_cmp_reg   <= pwm_out_pkg::TRIGGER_COMPARE_RST;
    end else if (wr_pend_reg) begin
      // no run-enable interlock: changing mode while running is the user's hazard
      if (wr_addr_reg == pwm_out_pkg::PIN_OUTPUT_CONTROL_OFS) begin
        pin_cfg_reg <= hwdata[15:0];
      end
      if (wr_addr_reg == pwm_out_pkg::FAULT_LIMIT_CONTROL_OFS) begin
        fault_cfg_reg <= hwdata[15:0];
      end
      if (wr_addr_reg == pwm_out_pkg::PRIMARY_TRIGGER_OFS) begin
        prim_cmp_reg <= hwdata[15:pwm_out_pkg::TRIG_CMP_LSB];
      end
      if (wr_addr_reg == pwm_out_pkg::SECONDARY_TRIGGER_OFS) begin
        sec_cmp_reg <= hwdata[15:pwm_out_pkg::TRIG_CMP_LSB];
      end
    end
  end

  assign latch_clear = wr_pend_reg & (wr_addr_reg == pwm_out_pkg::OUTPUT_STATUS_OFS)
                       & hwdata[pwm_out_pkg::STAT_FAULT_LATCHED];

  // fault pins are asynchronous, two flops before use
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fault_sync1_reg <= 8'h00;
      fault_sync2_reg <= 8'h00;
    end else begin
      fault_sync1_reg <= fault_in;
      fault_sync2_reg <= fault_sync1_reg;
    end
  end

  // source selection and polarity
  always_comb begin
    fault_act = pick_source(fault_cfg_reg.fault_source_select, fault_sync2_reg)
                ^ fault_cfg_reg.fault_source_polarity;
    limit_act = pick_source(fault_cfg_reg.limit_source_select, fault_sync2_reg)
                ^ fault_cfg_reg.limit_source_polarity;
    // reserved source codes with active-low polarity would read as active; keep them quiet
    if (fault_cfg_reg.fault_source_select[4:3] != 2'h0) begin
      fault_act = 1'b0;
    end
    if (fault_cfg_reg.limit_source_select[4:3] != 2'h0) begin
      limit_act = 1'b0;
    end
  end

  // fault memories; a fault still present wins over a clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fault_latched_reg <= 1'b0;
      fault_cycle_reg   <= 1'b0;
    end else begin
      if (fault_cfg_reg.fault_action_mode == pwm_out_pkg::FAULT_LATCHED && fault_act) begin
        fault_latched_reg <= 1'b1;
      end else if (latch_clear) begin
        fault_latched_reg <= 1'b0;
      end
      if (fault_cfg_reg.fault_action_mode == pwm_out_pkg::FAULT_CYCLE && fault_act) begin
        fault_cycle_reg <= 1'b1;
      end else if (tb_sync) begin
        fault_cycle_reg <= 1'b0;
      end
    end
  end

  // forcing conditions
  always_comb begin
    unique case (fault_cfg_reg.fault_action_mode)
      pwm_out_pkg::FAULT_LATCHED: fault_force = fault_act | fault_latched_reg;
      pwm_out_pkg::FAULT_CYCLE:   fault_force = fault_act | fault_cycle_reg;
      default:                    fault_force = 1'b0;
    endcase
    limit_force = limit_act & fault_cfg_reg.limit_function_enable;
  end

  // push-pull alternates the active pin every pwm cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      push_phase_reg <= 1'b0;
    end else if (tb_sync) begin
      push_phase_reg <= ~push_phase_reg;
    end
  end

  // override applied at once, or only at the cycle boundary when synced
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ovr_reg <= '0;
    end else if (!pin_cfg_reg.override_sync || tb_sync) begin
      ovr_reg.high_enable <= pin_cfg_reg.high_override_enable;
      ovr_reg.low_enable  <= pin_cfg_reg.low_override_enable;
      ovr_reg.data        <= pin_cfg_reg.override_data;
    end
  end

  // pairing of generator signals
  always_comb begin
    unique case (pin_cfg_reg.pair_output_mode)
      pwm_out_pkg::PAIR_COMPLEMENTARY: begin
        pair_high = gen_high;
        pair_low  = ~gen_high;
      end
      pwm_out_pkg::PAIR_REDUNDANT: begin
        pair_high = gen_high;
        pair_low  = gen_high;
      end
      pwm_out_pkg::PAIR_PUSH_PULL: begin
        pair_high = gen_high & ~push_phase_reg;
        pair_low  = gen_high & push_phase_reg;
      end
      pwm_out_pkg::PAIR_INDEPENDENT: begin
        pair_high = gen_high;
        pair_low  = gen_low;
      end
    endcase
  end

  // override, then limit, then fault; fault is the last word
  always_comb begin
    sig_high = ovr_reg.high_enable ? ovr_reg.data[1] : pair_high;
    sig_low  = ovr_reg.low_enable  ? ovr_reg.data[0] : pair_low;
    if (fault_cfg_reg.independent_fault_mode) begin
      if (limit_force) begin
        sig_high = pin_cfg_reg.fault_drive_data[1];
      end
      if (fault_force) begin
        sig_low = pin_cfg_reg.fault_drive_data[0];
      end
    end else begin
      if (limit_force) begin
        sig_high = pin_cfg_reg.limit_drive_data[1];
        sig_low  = pin_cfg_reg.limit_drive_data[0];
      end
      if (fault_force) begin
        sig_high = pin_cfg_reg.fault_drive_data[1];
        sig_low  = pin_cfg_reg.fault_drive_data[0];
      end
    end
  end

  // swap, polarity and ownership
  always_comb begin
    pin_high_next = pin_cfg_reg.pin_swap ? sig_low : sig_high;
    pin_low_next  = pin_cfg_reg.pin_swap ? sig_high : sig_low;
    pin_high_next = pin_high_next ^ pin_cfg_reg.high_pin_polarity;
    pin_low_next  = pin_low_next ^ pin_cfg_reg.low_pin_polarity;
    if (!pin_cfg_reg.high_pin_ownership) begin
      pin_high_next = gpio_high;
    end
    if (!pin_cfg_reg.low_pin_ownership) begin
      pin_low_next = gpio_low;
    end
  end

  // pin registers, one cycle of latency
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      high_side_output <= 1'b0;
      low_side_output  <= 1'b0;
      high_pin_owned   <= 1'b0;
      low_pin_owned    <= 1'b0;
    end else begin
      high_side_output <= pin_high_next;
      low_side_output  <= pin_low_next;
      high_pin_owned   <= pin_cfg_reg.high_pin_ownership;
      low_pin_owned    <= pin_cfg_reg.low_pin_ownership;
    end
  end

  // compare ignores the low three count bits
  assign prim_hit = (tb_count[15:3] == prim_cmp_reg) & ~prim_match_reg;
  assign sec_hit  = (sec_tb_count[15:3] == sec_cmp_reg) & ~sec_match_reg;

  // trigger pulses on the first cycle of a match
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prim_match_reg     <= 1'b0;
      sec_match_reg      <= 1'b0;
      adc_trig_primary   <= 1'b0;
      adc_trig_secondary <= 1'b0;
      trig_int_req       <= 1'b0;
    end else begin
      prim_match_reg     <= tb_count[15:3] == prim_cmp_reg;
      sec_match_reg      <= sec_tb_count[15:3] == sec_cmp_reg;
      adc_trig_primary   <= prim_hit;
      adc_trig_secondary <= sec_hit;
      trig_int_req       <= prim_hit;
    end
  end

  // checks
  a_gpio_owns_pin: assert property (
    !pin_cfg_reg.high_pin_ownership |=> high_side_output == $past(gpio_high))
    else $error("high pin not from gpio when unowned");

  a_high_override_pol: assert property (
    pin_cfg_reg.high_pin_ownership && ovr_reg.high_enable && !fault_force && !limit_force
    && !pin_cfg_reg.pin_swap
    |=> high_side_output == ($past(ovr_reg.data[1]) ^ $past(pin_cfg_reg.high_pin_polarity)))
    else $error("high override or polarity wrong");

  a_low_override_pol: assert property (
    pin_cfg_reg.low_pin_ownership && ovr_reg.low_enable && !fault_force && !limit_force
    && !pin_cfg_reg.pin_swap
    |=> low_side_output == ($past(ovr_reg.data[0]) ^ $past(pin_cfg_reg.low_pin_polarity)))
    else $error("low override or polarity wrong");

  a_swap_routes_low: assert property (
    pin_cfg_reg.high_pin_ownership && pin_cfg_reg.pin_swap
    |=> high_side_output == ($past(sig_low) ^ $past(pin_cfg_reg.high_pin_polarity)))
    else $error("swap did not route low signal to high pin");

  a_sync_holds_ovr: assert property (
    pin_cfg_reg.override_sync && !tb_sync |=> $stable(ovr_reg))
    else $error("synced override changed off the time base");

  a_limit_normal: assert property (
    !fault_cfg_reg.independent_fault_mode && limit_force && !fault_force
    && pin_cfg_reg.high_pin_ownership && !pin_cfg_reg.pin_swap
    |=> high_side_output == ($past(pin_cfg_reg.limit_drive_data[1])
                             ^ $past(pin_cfg_reg.high_pin_polarity)))
    else $error("limit data not on high pin");

  a_fault_latch_set: assert property (
    fault_cfg_reg.fault_action_mode == pwm_out_pkg::FAULT_LATCHED && fault_act
    |=> fault_latched_reg)
    else $error("latched fault not remembered");

  a_fault_disabled: assert property (
    fault_cfg_reg.fault_action_mode == pwm_out_pkg::FAULT_DISABLED |-> !fault_force)
    else $error("disabled fault still forcing");

  a_reserved_source: assert property (
    fault_cfg_reg.fault_source_select[4:3] != 2'h0 |-> !fault_act)
    else $error("reserved fault source selected an input");

  a_secondary_no_irq: assert property (
    adc_trig_secondary && !adc_trig_primary |-> !trig_int_req)
    else $error("secondary trigger raised interrupt");

  a_primary_trigger: assert property (
    tb_count[15:3] == prim_cmp_reg && !prim_match_reg |=> adc_trig_primary ##1 !adc_trig_primary)
    else $error("primary trigger pulse wrong");

  a_indep_fault_low: assert property (
    fault_cfg_reg.independent_fault_mode && fault_force && pin_cfg_reg.low_pin_ownership
    && !pin_cfg_reg.pin_swap
    |=> low_side_output == ($past(pin_cfg_reg.fault_drive_data[0])
                            ^ $past(pin_cfg_reg.low_pin_polarity)))
    else $error("independent fault did not force low pin");

endmodule // pwm_output_fault_trigger_ctrl

// [pwm_output_fault_trigger_ctrl_tb.sv]
// testbench: register bus, pin path, fault and limit forcing, adc triggers
`timescale 1ns/1ps

`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module pwm_output_fault_trigger_ctrl_tb;
  typedef struct packed {
    logic [15:0] cfg;  // pin output control value
    logic [3:0]  in;   // gen_high, gen_low, gpio_high, gpio_low
    logic [1:0]  ex;   // expected high, low pin
  } row_t;
  logic        core_clk, rstn, hsel, hwrite, hreadyout, hresp;
  logic [7:0]  haddr, fault_in, sense;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, rd;
  logic        gen_high, gen_low, gpio_high, gpio_low, hs, ls, tp, tsec, ti, ho, lo, sync;
  logic [15:0] tb_count, sec_tb_count;
  int          n_errors, checked;
  // one row per pairing mode, polarity, swap, override, gpio ownership
  row_t rows [8] = '{'{16'hc000, 4'h8, 2'h2}, '{16'hc400, 4'h8, 2'h3},
    '{16'hc800, 4'h0, 2'h0}, '{16'hcc00, 4'h4, 2'h1}, '{16'hf000, 4'h8, 2'h1},
    '{16'hc002, 4'h8, 2'h1}, '{16'hcf80, 4'h4, 2'h2}, '{16'h0000, 4'h9, 2'h1}};

  pwm_output_fault_trigger_ctrl dut (.core_clk(core_clk), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .gen_high(gen_high), .gen_low(gen_low), .tb_sync(sync), .tb_count(tb_count),
    .sec_tb_count(sec_tb_count), .gpio_high(gpio_high), .gpio_low(gpio_low),
    .fault_in(fault_in), .high_side_output(hs), .low_side_output(ls),
    .high_pin_owned(ho), .low_pin_owned(lo), .adc_trig_primary(tp),
    .adc_trig_secondary(tsec), .trig_int_req(ti));
  pwm_switch_model sw (.core_clk(core_clk), .sense_req(sense), .fault_in(fault_in));

  // free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task close_out;
    $display("n_errors=%0d checked=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // a wait that used up its bound ends the run
  task tmo(input int n);
    if (n >= 40) begin
      n_errors++;
      close_out();
    end
  endtask
  // one single ahb-lite transfer, waits on hready in both phases
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    n = 0;
    do begin @(posedge core_clk); n++; end while (hreadyout !== 1'b1 && n < 40);
    tmo(n);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    n = 0;
    do begin @(posedge core_clk); n++; end while (hreadyout !== 1'b1 && n < 40);
    tmo(n);
    rd = hrdata;
  endtask
  // let pins settle, fault lines need the extra sync stages
  task settle;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  // one time-base sync pulse, launched on a rising edge
  task pulse_sync;
    @(posedge core_clk);
    sync <= 1'b1;
    @(posedge core_clk);
    sync <= 1'b0;
  endtask
  // wait for a trigger pulse, checked at the falling edge
  task automatic wait_trig(input logic sec);
    int n;
    n = 0;
    while ((sec ? tsec : tp) !== 1'b1 && n < 40) begin @(negedge core_clk); n++; end
    tmo(n);
  endtask

  initial begin
    {rstn, hsel, hwrite, haddr, htrans, hwdata, sense, sync} = '0;
    {gen_high, gen_low, gpio_high, gpio_low, tb_count, sec_tb_count} = '0;
    n_errors = 0;
    checked = 0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    xfer(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h0)
    xfer(1'b0, 8'h04, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(hresp, 1'b0)
    // ordinary cases from the table
    foreach (rows[i]) begin
      xfer(1'b1, 8'h00, {16'h0000, rows[i].cfg});
      {gen_high, gen_low, gpio_high, gpio_low} <= rows[i].in;
      settle();
      `CHK({hs, ls}, rows[i].ex)
    end
    `CHK({ho, lo}, 2'h0)
    // latched fault on input 1 wins over the generator until cleared
    xfer(1'b1, 8'h00, 32'h0000c010);
    {gen_high, gen_low} <= 2'h2;
    sense <= 8'h01;
    settle();
    `CHK({hs, ls}, 2'h1)
    `CHK({ho, lo}, 2'h3)
    sense <= 8'h00;
    settle();
    `CHK({hs, ls}, 2'h1)
    xfer(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h00000001)
    xfer(1'b1, 8'h10, 32'h1);
    settle();
    `CHK({hs, ls}, 2'h2)
    xfer(1'b1, 8'h04, 32'h00000003);
    sense <= 8'h01;
    settle();
    `CHK({hs, ls}, 2'h2)
    // active-low current limit on input 2 drives limit data
    xfer(1'b1, 8'h04, 32'h00000703);
    xfer(1'b1, 8'h00, 32'h0000c00c);
    sense <= 8'h02;
    settle();
    `CHK({hs, ls}, 2'h2)
    sense <= 8'h00;
    settle();
    `CHK({hs, ls}, 2'h3)
    xfer(1'b1, 8'h04, 32'h00002303);
    settle();
    `CHK({hs, ls}, 2'h2)
    // independent fault mode, cycle by cycle; sources kept apart
    // setup is written while gen_high stays at 1; there is no run-enable interlock
    xfer(1'b1, 8'h00, 32'h0000c01c);
    xfer(1'b1, 8'h04, 32'h00008501);
    sense <= 8'h01;
    settle();
    `CHK({hs, ls}, 2'h3)
    sense <= 8'h00;
    settle();
    `CHK({hs, ls}, 2'h3)
    pulse_sync();
    settle();
    `CHK({hs, ls}, 2'h2)
    sense <= 8'h02;
    settle();
    `CHK({hs, ls}, 2'h0)
    // push-pull alternates on each time-base sync
    sense <= 8'h00;
    xfer(1'b1, 8'h04, 32'h00000003);
    xfer(1'b1, 8'h00, 32'h0000c800);
    settle();
    `CHK({hs, ls}, 2'h1)
    pulse_sync();
    settle();
    `CHK({hs, ls}, 2'h2)
    // synced override waits for the time base
    xfer(1'b1, 8'h00, 32'h0000c341);
    settle();
    `CHK({hs, ls}, 2'h2)
    pulse_sync();
    settle();
    `CHK({hs, ls}, 2'h1)
    // trigger compares: low bits read zero, only primary interrupts
    xfer(1'b1, 8'h08, 32'h00000017);
    xfer(1'b0, 8'h08, 32'h0);
    `CHK(rd, 32'h00000010)
    tb_count <= 16'h0010;
    wait_trig(1'b0);
    `CHK(ti, 1'b1)
    xfer(1'b1, 8'h0c, 32'h0000002f);
    xfer(1'b0, 8'h0c, 32'h0);
    `CHK(rd, 32'h00000028)
    sec_tb_count <= 16'h0028;
    wait_trig(1'b1);
    `CHK(ti, 1'b0)
    xfer(1'b0, 8'h14, 32'h0);
    `CHK(rd, 32'h0)
    // mid-run reset: outputs drop at once except hreadyout, which stays high; registers clear
    @(posedge core_clk);
    rstn <= 1'b0;
    @(negedge core_clk);
    `CHK({hs, ls, ho, lo, tp, tsec, ti, hreadyout}, 8'h01)
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    xfer(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h0)
    xfer(1'b0, 8'h0c, 32'h0);
    `CHK(rd, 32'h0)
    close_out();
  end
endmodule // pwm_output_fault_trigger_ctrl_tb

// [pwm_switch_model.sv]
// far-side model: fault and current-limit sensors on the power switches
`timescale 1ns/1ps

module pwm_switch_model (
  input  wire logic       core_clk,   // core clock, sensor lines move on its falling edge
  input  wire logic [7:0] sense_req,  // sensor trip levels set by the bench
  output logic      [7:0] fault_in    // fault lines 1..8 into the block
);
  // lines move half a period away from the sampling edge, so the synchroniser
  // never sees a change on its own edge; known level from the first falling edge
  always @(negedge core_clk) begin
    fault_in <= sense_req;
  end
endmodule // pwm_switch_model
